/* rtl/ccr_pkg.sv */
// Constants and types of the charger control register bank
package ccr_pkg;
  // ****************************************
  // Bus addressing
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h6B;
  localparam logic [7:0] OFS_INLIM = 8'h00;
  localparam logic [7:0] OFS_PWR = 8'h01;
  localparam logic [7:0] OFS_CHG = 8'h02;
  localparam logic [7:0] NUM_REGS = 8'h03;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // ****************************************
  // Power-on values and watchdog masks
  // ****************************************
  localparam logic [7:0] RST_INLIM = 8'h17;
  localparam logic [7:0] RST_PWR = 8'h1A;
  localparam logic [7:0] RST_CHG = 8'hA2;
  localparam logic [7:0] WD_INLIM = 8'h80;
  localparam logic [7:0] WD_PWR = 8'h70;
  localparam logic [7:0] WD_CHG = 8'hBF;
  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int B_HIZ = 7;
  localparam int B_STAT = 5;
  localparam int B_PFM = 7;
  localparam int B_KICK = 6;
  localparam int B_BOOST = 5;
  localparam int B_CHG = 4;
  localparam int B_SYS = 1;
  localparam int B_MINV = 0;
  localparam int B_BLIM = 7;
  localparam int B_FET = 6;
  localparam logic [1:0] STAT_OFF = 2'h3;
  localparam logic [4:0] IIN_CODE_PSEL_HI = 5'h04;
  localparam logic [4:0] IIN_CODE_PSEL_LO = 5'h17;
  localparam logic [5:0] FAST_CHARGE_CURRENT_CODE_MAX = 6'h32;
  // ****************************************
  // Scales in mA and mV
  // ****************************************
  localparam logic [11:0] IIN_OFS_MA = 12'h064;
  localparam logic [11:0] IIN_STEP_MA = 12'h064;
  localparam logic [11:0] FAST_CHARGE_CURRENT_STEP_MA = 12'h03C;
  localparam logic [11:0] FET_THR_MA = 12'h2BC;
  localparam logic [11:0] BOOST_LO_MA = 12'h1F4;
  localparam logic [11:0] BOOST_HI_MA = 12'h4B0;
  localparam logic [11:0] VBAT_FALL0_MV = 12'hAF0;
  localparam logic [11:0] VBAT_FALL1_MV = 12'h9C4;
  localparam logic [11:0] VBAT_RISE_MV = 12'hBB8;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WR, ST_ACK, ST_RD, ST_RACK
  } ccr_state_e;
  typedef struct packed {
    logic hiz;
    logic stat_off;
    logic light_load_mode_disable;
    logic chg_en;
    logic boost_en;
    logic fet_high_r;
    logic [2:0] system_min_voltage;
    logic [11:0] iin_ma;
    logic [11:0] fast_charge_current_ma;
    logic [11:0] boost_ma;
    logic [11:0] vbat_fall_mv;
    logic [11:0] vbat_rise_mv;
  } ccr_cfg_s;
  typedef struct packed {
    ccr_state_e state;
    ccr_state_e ret;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic nack;
    logic scl_q;
    logic sda_q;
    logic sda_o;
    logic sda_oe;
    logic wd_kick;
    logic [2:0][7:0] regs;
    ccr_cfg_s cfg;
  } ccr_st_s;
endpackage

/* rtl/ccr_regs.sv */
// Charger control registers 0 to 2 behind a two-wire serial slave
//
// Behaviour
// R1 - Input limit is 100 mA plus 100 mA/step
// R2 - Detection loads 500 mA or 2.4 A by pin
// R3 - Host may overwrite input limit after detection
// R4 - Watchdog kick bit restarts timer, self-clears
// R5 - Boost enable overrides charge enable
// R6 - Charge needs pin low and bit set
// R7 - Min battery bit picks 2.8 or 2.5 V
// R8 - Boost limit bit picks 0.5 or 1.2 A
// R9 - Small input limit uses high-resistance FET
// R10 - Zero fast charge code disables charging
// R11 - Fast charge 60 mA/step, clamp to 0x32
// R12 - Slave at fixed address, standard and fast rates
// R13 - Watchdog expiry restores only watchdog fields
`timescale 1ns/1ps
module ccr_regs
  import ccr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic psel_in,
  input wire logic det_done_in,
  input wire logic ce_n_in,
  input wire logic reg_reset_in,
  input wire logic wd_expire_in,
  output logic wd_kick_out,
  output ccr_cfg_s cfg_out
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [11:0] iin_ma(input logic [4:0] code);
    iin_ma = 12'(IIN_OFS_MA + 12'(code) * IIN_STEP_MA); // R1
  endfunction
  function automatic logic [11:0] fast_charge_current_ma(input logic [5:0] code);
    fast_charge_current_ma = 12'(12'(code) * FAST_CHARGE_CURRENT_STEP_MA); // R11
  endfunction
  function automatic logic [7:0] rd_reg(input logic [2:0][7:0] r,
                                        input logic [7:0] p);
    rd_reg = (p < NUM_REGS) ? r[p[1:0]] : 8'h00;
  endfunction
  function automatic logic [7:0] wr_val(input logic [7:0] p,
                                        input logic [7:0] d);
    wr_val = (p == OFS_CHG && d[5:0] > FAST_CHARGE_CURRENT_CODE_MAX)
             ? {d[7:6], FAST_CHARGE_CURRENT_CODE_MAX} : d; // R11
  endfunction
  function automatic logic [7:0] wd_fix(input logic [7:0] cur,
                                        input logic [7:0] por,
                                        input logic [7:0] msk);
    wd_fix = (cur & ~msk) | (por & msk); // R13
  endfunction
  ccr_st_s st;
  ccr_st_s next_st;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  assign rise = scl_in & ~st.scl_q;
  assign fall = ~scl_in & st.scl_q;
  assign start = scl_in & st.scl_q & st.sda_q & ~sda_in;
  assign stop = scl_in & st.scl_q & ~st.sda_q & sda_in;
  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.scl_q = scl_in;
    next_st.sda_q = sda_in;
    next_st.sda_o = 1'b0;
    next_st.regs[1][B_KICK] = 1'b0; // R4
    if (det_done_in)
    begin
      next_st.regs[0][4:0] = psel_in ? IIN_CODE_PSEL_HI
                                     : IIN_CODE_PSEL_LO; // R2
    end
    if (start)
    begin
      next_st.state = ST_ADDR;
      next_st.cnt = 4'h0;
      next_st.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      next_st.state = ST_IDLE;
      next_st.sda_oe = 1'b0;
    end
    else
    begin
      case (st.state)
        ST_ADDR, ST_REG, ST_WR:
        begin
          if (rise)
          begin
            next_st.sh = {st.sh[6:0], sda_in};
            next_st.cnt = 4'(st.cnt + 4'h1);
          end
          else if (fall && st.cnt == BYTE_BITS)
          begin
            next_st.cnt = 4'h0;
            next_st.state = ST_ACK;
            next_st.sda_oe = 1'b1;
            if (st.state == ST_ADDR)
            begin
              next_st.ret = st.sh[0] ? ST_RD : ST_REG;
              if (st.sh[7:1] != DEV_ADDR) // R12
              begin
                next_st.state = ST_IDLE;
                next_st.sda_oe = 1'b0;
              end
            end
            else if (st.state == ST_REG)
            begin
              next_st.ptr = st.sh;
              next_st.ret = ST_WR;
            end
            else
            begin
              if (st.ptr < NUM_REGS)
              begin
                next_st.regs[st.ptr[1:0]] = wr_val(st.ptr, st.sh); // R3
              end
              next_st.ptr = 8'(st.ptr + 8'h01);
              next_st.ret = ST_WR;
            end
          end
        end
        ST_ACK:
        begin
          if (fall)
          begin
            next_st.state = st.ret;
            next_st.sda_oe = 1'b0;
            if (st.ret == ST_RD)
            begin
              next_st.sh = rd_reg(st.regs, st.ptr);
              next_st.sda_oe = ~next_st.sh[7];
            end
          end
        end
        ST_RD:
        begin
          if (fall)
          begin
            next_st.cnt = 4'(st.cnt + 4'h1);
            next_st.sh = {st.sh[6:0], 1'b0};
            next_st.sda_oe = ~st.sh[6];
            if (st.cnt == LAST_BIT)
            begin
              next_st.state = ST_RACK;
              next_st.sda_oe = 1'b0;
            end
          end
        end
        ST_RACK:
        begin
          if (rise)
          begin
            next_st.nack = sda_in;
          end
          else if (fall)
          begin
            if (st.nack)
            begin
              next_st.state = ST_IDLE;
            end
            else
            begin
              next_st.ptr = 8'(st.ptr + 8'h01);
              next_st.cnt = 4'h0;
              next_st.sh = rd_reg(st.regs, next_st.ptr);
              next_st.sda_oe = ~next_st.sh[7];
              next_st.state = ST_RD;
            end
          end
        end
        default:
          next_st.state = ST_IDLE;
      endcase
    end
    if (wd_expire_in)
    begin
      next_st.regs[0] = wd_fix(next_st.regs[0], RST_INLIM, WD_INLIM); // R13
      next_st.regs[1] = wd_fix(next_st.regs[1], RST_PWR, WD_PWR); // R13
      next_st.regs[2] = wd_fix(next_st.regs[2], RST_CHG, WD_CHG); // R13
    end
    if (reg_reset_in)
    begin
      next_st.regs = {RST_CHG, RST_PWR, RST_INLIM};
    end
    next_st.wd_kick = next_st.regs[1][B_KICK]; // R4
    next_st.cfg.hiz = next_st.regs[0][B_HIZ];
    next_st.cfg.stat_off = next_st.regs[0][B_STAT+:2] == STAT_OFF;
    next_st.cfg.light_load_mode_disable = next_st.regs[1][B_PFM];
    next_st.cfg.boost_en = next_st.regs[1][B_BOOST];
    next_st.cfg.chg_en = ~ce_n_in & next_st.regs[1][B_CHG] // R6
                         & ~next_st.regs[1][B_BOOST] // R5
                         & (next_st.regs[2][5:0] != 6'h00); // R10
    next_st.cfg.system_min_voltage = next_st.regs[1][B_SYS+:3];
    next_st.cfg.iin_ma = iin_ma(next_st.regs[0][4:0]); // R1
    next_st.cfg.fast_charge_current_ma = fast_charge_current_ma(next_st.regs[2][5:0]); // R11
    next_st.cfg.fet_high_r = ~next_st.regs[1][B_BOOST]
                             & ~next_st.regs[2][B_FET]
                             & (next_st.cfg.iin_ma < FET_THR_MA); // R9
    next_st.cfg.boost_ma = next_st.regs[2][B_BLIM] ? BOOST_HI_MA
                                                   : BOOST_LO_MA; // R8
    next_st.cfg.vbat_fall_mv = next_st.regs[1][B_MINV] ? VBAT_FALL1_MV
                                                       : VBAT_FALL0_MV; // R7
    next_st.cfg.vbat_rise_mv = VBAT_RISE_MV; // R7
  end
  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.regs <= {RST_CHG, RST_PWR, RST_INLIM};
      st.cfg.iin_ma <= iin_ma(RST_INLIM[4:0]);
      st.cfg.fast_charge_current_ma <= fast_charge_current_ma(RST_CHG[5:0]);
      st.cfg.system_min_voltage <= RST_PWR[B_SYS+:3];
      st.cfg.boost_ma <= BOOST_HI_MA;
      st.cfg.vbat_fall_mv <= VBAT_FALL0_MV;
      st.cfg.vbat_rise_mv <= VBAT_RISE_MV;
    end
    else
    begin
      st <= next_st;
    end
  end
  assign sda_out = st.sda_o;
  assign sda_oe_out = st.sda_oe;
  assign wd_kick_out = st.wd_kick;
  assign cfg_out = st.cfg;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_iin_scale: assert property ( // R1
    cfg_out.iin_ma == iin_ma(st.regs[0][4:0]))
    else $error("input limit scale wrong");
  chk_det_load: assert property ( // R2
    det_done_in && !reg_reset_in && st.state == ST_IDLE |=>
    st.regs[0][4:0] == ($past(psel_in) ? IIN_CODE_PSEL_HI : IIN_CODE_PSEL_LO))
    else $error("detection load wrong");
  chk_host_keep: assert property ( // R3
    !det_done_in && !reg_reset_in && st.state == ST_IDLE |=>
    $stable(st.regs[0][4:0]))
    else $error("input limit changed without cause");
  chk_kick_clear: assert property ( // R4
    st.regs[1][B_KICK] |-> wd_kick_out ##1 !st.regs[1][B_KICK])
    else $error("kick bit not self cleared");
  chk_boost_prec: assert property ( // R5
    cfg_out.boost_en |-> !cfg_out.chg_en)
    else $error("charging during boost");
  chk_chg_gate: assert property ( // R6
    $past(rst_n_in) |-> cfg_out.chg_en == ($past(!ce_n_in) &&
    st.regs[1][B_CHG] && !st.regs[1][B_BOOST] && st.regs[2][5:0] != 6'h00))
    else $error("charge enable gating wrong");
  chk_vbat_sel: assert property ( // R7
    cfg_out.vbat_fall_mv == (st.regs[1][B_MINV] ? VBAT_FALL1_MV
                                                : VBAT_FALL0_MV))
    else $error("battery threshold wrong");
  chk_boost_current_limit: assert property ( // R8
    cfg_out.boost_ma == (st.regs[2][B_BLIM] ? BOOST_HI_MA : BOOST_LO_MA))
    else $error("boost limit wrong");
  chk_fet_sel: assert property ( // R9
    cfg_out.fet_high_r |-> !st.regs[2][B_FET] && !cfg_out.boost_en &&
    cfg_out.iin_ma < FET_THR_MA)
    else $error("input FET select wrong");
  chk_fast_charge_current_clamp: assert property ( // R11
    st.regs[2][5:0] <= FAST_CHARGE_CURRENT_CODE_MAX && cfg_out.fast_charge_current_ma <= 12'hBB8)
    else $error("fast charge code above clamp");
  chk_addr_nack: assert property ( // R12
    st.state == ST_ADDR && fall && !start && !stop && st.cnt == BYTE_BITS
    && st.sh[7:1] != DEV_ADDR |=> st.state == ST_IDLE && !sda_oe_out)
    else $error("foreign address acknowledged");
  chk_wd_restore: assert property ( // R13
    wd_expire_in && !reg_reset_in && !fall |=>
    st.regs[1][B_CHG+:3] == RST_PWR[B_CHG+:3] && $stable(st.regs[2][B_FET]))
    else $error("watchdog restore wrong");
  cov_det_hi: cover property (det_done_in && psel_in);
  cov_rd_burst: cover property (st.state == ST_RACK && fall && !st.nack);
  cov_kick: cover property (wd_kick_out);
  cov_write: cover property (st.state == ST_WR && st.cnt == BYTE_BITS && fall);
endmodule

/* sim/ccr_host.sv */
// Host controller model driving the two-wire serial pins
`timescale 1ns/1ps
module ccr_host
  import ccr_pkg::*;
(
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out,
  output logic [7:0] rd_out,
  output logic rd_vld_out
);
  // ****************************************
  // Bit, byte and transfer tasks
  // ****************************************
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    rd_out = 8'h00;
    rd_vld_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_low_out <= !b;
    tick(4);
    scl_out <= 1'b1;
    tick(3);
    s = sda_in;
    tick(2);
    scl_out <= 1'b0;
    tick(1);
  endtask
  task automatic start;
    sda_low_out <= 1'b0;
    tick(4);
    scl_out <= 1'b1;
    tick(5);
    sda_low_out <= 1'b1;
    tick(5);
    scl_out <= 1'b0;
    tick(1);
  endtask
  task automatic stop;
    sda_low_out <= 1'b1;
    tick(4);
    scl_out <= 1'b1;
    tick(5);
    sda_low_out <= 1'b0;
    tick(5);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
    input logic [7:0] d, output logic ack);
    logic k0, k1, k2;
    start();
    tx({a, 1'b0}, k0);
    tx(p, k1);
    tx(d, k2);
    stop();
    ack = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic k;
    logic [7:0] b;
    start();
    tx({DEV_ADDR, 1'b0}, k);
    tx(p, k);
    start();
    tx({DEV_ADDR, 1'b1}, k);
    for (int j = 0; j < n; j++)
    begin
      for (int i = 7; i >= 0; i--)
        clk_bit(1'b1, b[i]);
      rd_out <= b;
      rd_vld_out <= 1'b1;
      tick(1);
      rd_vld_out <= 1'b0;
      clk_bit(j == n - 1, k);
    end
    stop();
  endtask
endmodule

/* sim/ccr_regs_tb.sv */
// Self-checking bench for the charger control registers
`timescale 1ns/1ps
module ccr_regs_tb;
  import ccr_pkg::*;
  // ****************************************
  // Signals, instances and checking
  // ****************************************
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic ce_n = 1'b0;
  logic [2:0] side = 3'h0;
  logic scl, sda_low, sda_o, sda_oe, kick, rd_vld, k;
  wire sda = !(sda_low | (sda_oe & !sda_o));
  logic [7:0] rd_b;
  ccr_cfg_s cfg;
  logic [7:0] q[$];
  logic [7:0] v[3];
  logic [5:0] tbl[4] = '{6'h00, 6'h32, 6'h33, 6'h3F};
  logic [5:0] c, e;
  int n_fail = 0;
  int compares = 0;
  int kicks = 0;
  int seed = 58709;
  always #2 ref_clk = !ref_clk;
  ccr_regs dut (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .psel_in(psel),
    .det_done_in(side[2]), .ce_n_in(ce_n), .reg_reset_in(side[1]),
    .wd_expire_in(side[0]), .wd_kick_out(kick), .cfg_out(cfg));
  ccr_host host (.clk_in(ref_clk), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low), .rd_out(rd_b), .rd_vld_out(rd_vld));
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk)
  begin
    if (rd_vld === 1'b1)
    begin
      if (q.size() == 0)
        check({4'h0, rd_b}, 12'hFFF);
      else
        check({4'h0, rd_b}, {4'h0, q.pop_front()});
    end
    if (kick === 1'b1)
      kicks++;
  end
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.wr(DEV_ADDR, p, d, k);
    check({11'h000, k}, 12'h001);
  endtask
  task automatic pulse(input logic [2:0] s);
    side <= s;
    @(posedge ref_clk);
    side <= 3'h0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && compares > 0 && q.size() == 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    q = '{RST_INLIM, RST_PWR, RST_CHG};
    host.rd(OFS_INLIM, 3);
    check(cfg.iin_ma, 12'h960);
    check(cfg.fast_charge_current_ma, 12'h7F8);
    check(cfg.boost_ma, BOOST_HI_MA);
    check(cfg.vbat_fall_mv, VBAT_FALL0_MV);
    check(cfg.vbat_rise_mv, VBAT_RISE_MV);
    check({11'h000, cfg.chg_en}, 12'h001);
    psel <= 1'b1;
    pulse(3'h4);
    check(cfg.iin_ma, 12'h1F4);
    q.push_back({3'h0, IIN_CODE_PSEL_HI});
    host.rd(OFS_INLIM, 1);
    psel <= 1'b0;
    pulse(3'h4);
    check(cfg.iin_ma, 12'h960);
    c = 6'($unsigned($random(seed)) % 32);
    wr(OFS_INLIM, {3'h0, c[4:0]});
    check(cfg.iin_ma, IIN_OFS_MA + IIN_STEP_MA * c);
    wr(OFS_PWR, 8'h5A);
    check(12'(kicks), 12'h001);
    q.push_back(8'h1A);
    host.rd(OFS_PWR, 1);
    wr(OFS_PWR, 8'h3A);
    check({10'h000, cfg.boost_en, cfg.chg_en}, 12'h002);
    check({11'h000, cfg.fet_high_r}, 12'h000);
    wr(OFS_PWR, 8'h1B);
    check({10'h000, cfg.boost_en, cfg.chg_en}, 12'h001);
    check(cfg.vbat_fall_mv, VBAT_FALL1_MV);
    ce_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({11'h000, cfg.chg_en}, 12'h000);
    ce_n <= 1'b0;
    wr(OFS_PWR, 8'h0A);
    check({11'h000, cfg.chg_en}, 12'h000);
    wr(OFS_PWR, 8'h1A);
    for (int i = 0; i < 5; i++)
    begin
      c = (i == 4) ? 6'($unsigned($random(seed)) % 51) : tbl[i];
      wr(OFS_CHG, {2'h2, c});
      e = (c > FAST_CHARGE_CURRENT_CODE_MAX) ? FAST_CHARGE_CURRENT_CODE_MAX : c;
      check(cfg.fast_charge_current_ma, FAST_CHARGE_CURRENT_STEP_MA * e);
      check({11'h000, cfg.chg_en}, {11'h000, e != 6'h00});
      q.push_back({2'h2, e});
      host.rd(OFS_CHG, 1);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_INLIM, 8'h05 + 8'(i % 2));
      wr(OFS_CHG, {1'b0, i > 1, 6'h22});
      check({11'h000, cfg.fet_high_r}, {11'h000, i == 0});
      check(cfg.boost_ma, BOOST_LO_MA);
    end
    wr(8'h03, 8'h55);
    q.push_back(8'h00);
    host.rd(8'h03, 1);
    host.wr(DEV_ADDR ^ 7'h01, OFS_INLIM, 8'h1F, k);
    check({11'h000, k}, 12'h000);
    check(cfg.iin_ma, FET_THR_MA);
    v = '{8'hE6, 8'hAF, 8'h45};
    for (int i = 0; i < 3; i++)
      wr(8'(i), v[i]);
    check({6'h00, cfg.hiz, cfg.stat_off, cfg.light_load_mode_disable, cfg.system_min_voltage},
      12'h03F);
    pulse(3'h1);
    q.push_back((v[0] & ~WD_INLIM) | (RST_INLIM & WD_INLIM));
    q.push_back((v[1] & ~WD_PWR) | (RST_PWR & WD_PWR));
    q.push_back((v[2] & ~WD_CHG) | (RST_CHG & WD_CHG));
    host.rd(OFS_INLIM, 3);
    check({6'h00, cfg.hiz, cfg.stat_off, cfg.light_load_mode_disable, cfg.system_min_voltage},
      12'h01F);
    pulse(3'h2);
    q = '{RST_INLIM, RST_PWR, RST_CHG};
    host.rd(OFS_INLIM, 3);
    check({6'h00, cfg.hiz, cfg.stat_off, cfg.light_load_mode_disable, cfg.system_min_voltage},
      12'h005);
    print_verdict();
  end
endmodule
